// *** quad_uart_map_pkg.sv ***
// constants shared by the quad channel memory window decoder
package quad_uart_map_pkg;

  // ****************************************
  // window geometry
  // ****************************************
  localparam int unsigned ADDR_WIDTH = 32;
  localparam int unsigned WINDOW_LSB = 12;
  localparam int unsigned CHAN_COUNT = 4;
  localparam logic [9:0] REG_END = 10'h00F;
  localparam logic [9:0] CFG_BEGIN = 10'h080;
  localparam logic [9:0] CFG_END = 10'h09A;
  localparam logic [9:0] DATA_BEGIN = 10'h100;
  localparam logic [9:0] ERR_BEGIN = 10'h200;

  // ****************************************
  // shared configuration bytes, index from CFG_BEGIN
  // ****************************************
  localparam int unsigned CFG_BYTES = 28;
  localparam logic [4:0] IDX_INT_LAST = 5'h03;
  localparam logic [4:0] IDX_TIMER_GAP = 5'h05;
  localparam logic [4:0] IDX_EIGHT_X = 5'h08;
  localparam logic [4:0] IDX_FOUR_X = 5'h09;
  localparam logic [4:0] IDX_SOFT_RESET = 5'h0A;
  localparam logic [4:0] IDX_SLEEP = 5'h0B;
  localparam logic [4:0] IDX_REVISION = 5'h0C;
  localparam logic [4:0] IDX_DEVICE = 5'h0D;
  localparam logic [4:0] IDX_PIN_SEL_LO = 5'h13;
  localparam logic [4:0] IDX_PIN_SEL_HI = 5'h19;
  localparam logic [4:0] IDX_TAIL_GAP = 5'h1B;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] PIN_SEL_RESET = 8'hFF;

  // ****************************************
  // transmit staging
  // ****************************************
  localparam int unsigned TX_ENTRY_WIDTH = 37;
  localparam int unsigned TX_DEPTH = 2;

  typedef enum logic [2:0] {
    REGION_NONE,
    REGION_UART,
    REGION_CFG,
    REGION_DATA,
    REGION_ERR
  } region_type;

endpackage : quad_uart_map_pkg

// *** quad_uart_tx_buffer.sv ***
// small valid/ready staging fifo for transmit data words
`timescale 1ns/10ps
module quad_uart_tx_buffer #(
  parameter int unsigned WIDTH = 37,
  parameter int unsigned DEPTH = 2
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic push;
  logic pop;

  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem_q[rd_ptr_q];

  always_comb
  begin
    count_d = count_q;
    if (push && !pop)
    begin
      count_d = count_q + CNT_W'(1);
    end
    else if (pop && !push)
    begin
      count_d = count_q - CNT_W'(1);
    end
  end

  // flags kept as flops so both sides see registered handshakes
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      count_q <= '0;
      o_in_ready <= 1'b1;
      o_out_valid <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      o_in_ready <= (count_d != FULL_COUNT);
      o_out_valid <= (count_d != '0);
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + PTR_W'(1);
      end
      if (pop)
      begin
        rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + PTR_W'(1);
      end
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= i_in_data;
    end
  end

endmodule : quad_uart_tx_buffer

// *** quad_uart_shared_config.sv ***
// shared configuration bytes reached through every channel alias
`timescale 1ns/10ps
module quad_uart_shared_config
  import quad_uart_map_pkg::*;
#(
  parameter logic [7:0] DEV_REVISION = 8'h01,
  parameter logic [7:0] DEV_CODE = 8'h5A
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_wr,
  input wire logic [1:0] i_chan,
  input wire logic [2:0] i_word,
  input wire logic [3:0] i_lanes,
  input wire logic [31:0] i_wdata,
  input wire logic [31:0] i_int_flags,
  output logic [CFG_BYTES-1:0][7:0] o_image,
  output logic [7:0] o_eight_x,
  output logic [7:0] o_four_x,
  output logic [7:0] o_soft_reset,
  output logic [7:0] o_sleep
);
  // arbitrary neutral identity values above, not any real part

  logic [CFG_BYTES-1:0][7:0] byte_q;
  logic [7:0] own_mask;

  assign own_mask = 8'h01 << i_chan;

  // ****************************************
  // one storage byte per configuration entry
  // ****************************************
  genvar b;
  generate
    for (b = 0; b < CFG_BYTES; b++)
    begin : g_byte
      localparam logic [4:0] IDX = 5'(b);
      localparam logic [7:0] INIT =
        (IDX == IDX_PIN_SEL_LO || IDX == IDX_PIN_SEL_HI) ?
        PIN_SEL_RESET : CFG_RESET;
      localparam bit SHARED = (IDX == IDX_EIGHT_X) ||
        (IDX == IDX_FOUR_X) || (IDX == IDX_SOFT_RESET) ||
        (IDX == IDX_SLEEP);
      localparam bit LOCKED = (IDX <= IDX_INT_LAST) ||
        (IDX == IDX_TIMER_GAP) || (IDX == IDX_REVISION) ||
        (IDX == IDX_DEVICE) || (IDX == IDX_TAIL_GAP);
      logic hit;
      logic [7:0] wbyte;

      assign hit = i_wr && (i_word == IDX[4:2]) && i_lanes[b % 4];
      assign wbyte = i_wdata[(b % 4) * 8 +: 8];

      always_ff @(posedge i_clock)
      begin
        if (!i_rst_b)
        begin
          byte_q[b] <= INIT;
        end
        else if (LOCKED)
        begin
          byte_q[b] <= INIT;
        end
        else if (IDX == IDX_SOFT_RESET)
        begin
          // self clearing: a pulse one cycle after the write
          byte_q[b] <= hit ? (wbyte & own_mask) : CFG_RESET;
        end
        else if (hit && SHARED)
        begin
          byte_q[b] <= (byte_q[b] & ~own_mask) | (wbyte & own_mask);
        end
        else if (hit)
        begin
          byte_q[b] <= wbyte;
        end
      end

      always_comb
      begin
        if (IDX <= IDX_INT_LAST)
        begin
          o_image[b] = i_int_flags[(b % 4) * 8 +: 8];
        end
        else if (IDX == IDX_REVISION)
        begin
          o_image[b] = DEV_REVISION;
        end
        else if (IDX == IDX_DEVICE)
        begin
          o_image[b] = DEV_CODE;
        end
        else if (IDX == IDX_SOFT_RESET)
        begin
          // write-only byte reads back as zero
          o_image[b] = CFG_RESET;
        end
        else
        begin
          o_image[b] = byte_q[b];
        end
      end
    end
  endgenerate

  assign o_eight_x = byte_q[IDX_EIGHT_X];
  assign o_four_x = byte_q[IDX_FOUR_X];
  assign o_soft_reset = byte_q[IDX_SOFT_RESET];
  assign o_sleep = byte_q[IDX_SLEEP];

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  // ****************************************
  // checks
  // ****************************************
  other_bits_kept_a: assert property (
    (i_wr && i_word == 3'h2 && i_lanes[0]) |=>
      ((byte_q[IDX_EIGHT_X] ^ $past(byte_q[IDX_EIGHT_X])) &
       ~$past(own_mask)) == 8'h00)
    else $error("write changed another channel's sampling bit");

  alias_store_a: assert property (
    (i_wr && i_word == 3'h4 && i_lanes[0]) |=>
      byte_q[16] == $past(i_wdata[7:0]))
    else $error("alias write did not reach the shared byte");

  reset_pulse_a: assert property (
    (o_soft_reset != 8'h00) |=> $past(i_wr) || (o_soft_reset == 8'h00))
    else $error("soft reset bit did not clear itself");

endmodule : quad_uart_shared_config

// *** quad_uart_memory_map_decoder.sv ***
// memory window decoder for the four channel uart bridge
`timescale 1ns/10ps
module quad_uart_memory_map_decoder
  import quad_uart_map_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_base_load,
  input wire logic [ADDR_WIDTH-1:WINDOW_LSB] i_base_value,
  input wire logic [ADDR_WIDTH-1:0] i_addr,
  input wire logic [3:0] i_byte_en,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [511:0] i_uart_regs,
  output logic o_uart_wr,
  output logic o_uart_rd,
  output logic [1:0] o_uart_chan,
  output logic [3:0] o_uart_offset,
  output logic [3:0] o_uart_be,
  output logic [31:0] o_uart_wdata,
  input wire logic [127:0] i_rx_bytes,
  input wire logic [127:0] i_line_status_value,
  output logic o_rx_pop,
  output logic [1:0] o_rx_pop_chan,
  output logic [2:0] o_rx_pop_count,
  output logic o_tx_room,
  output logic o_tx_valid,
  output logic [1:0] o_tx_chan,
  output logic [2:0] o_tx_count,
  output logic [31:0] o_tx_bytes,
  input wire logic i_tx_ready,
  input wire logic [31:0] i_int_flags,
  output logic [3:0] o_eight_times_sampling_select,
  output logic [3:0] o_four_times_sampling_select,
  output logic [3:0] o_soft_reset,
  output logic [3:0] o_sleep
);
  import quad_uart_map_pkg::*;

  // ****************************************
  // window hit and region decode
  // ****************************************
  logic [ADDR_WIDTH-1:WINDOW_LSB] base_q;
  logic base_valid_q;
  logic hit;
  logic [1:0] chan;
  logic [9:0] loc;
  logic [9:0] aligned;
  logic [3:0] lanes;
  region_type region;

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      base_q <= '0;
      base_valid_q <= 1'b0;
    end
    else if (i_base_load)
    begin
      base_q <= i_base_value;
      base_valid_q <= 1'b1;
    end
  end

  assign hit = base_valid_q && i_addr[ADDR_WIDTH-1:WINDOW_LSB] == base_q;
  assign chan = i_addr[11:10];
  assign loc = i_addr[9:0];
  assign aligned = {loc[9:2], 2'b00};
  // lanes below the start address never take part
  assign lanes = i_byte_en & (4'hF << i_addr[1:0]);

  always_comb
  begin
    if (!hit)
    begin
      region = REGION_NONE;
    end
    else if (aligned >= ERR_BEGIN)
    begin
      region = REGION_ERR;
    end
    else if (aligned >= DATA_BEGIN)
    begin
      region = REGION_DATA;
    end
    else if (aligned >= CFG_BEGIN && aligned <= CFG_END)
    begin
      region = REGION_CFG;
    end
    else if (aligned <= REG_END)
    begin
      region = REGION_UART;
    end
    else
    begin
      region = REGION_NONE;
    end
  end

  // ****************************************
  // lane assembly for reads and transmit packing
  // ****************************************
  logic [CFG_BYTES-1:0][7:0] cfg_image;
  logic [31:0] rd_word;
  logic [31:0] tx_word;
  logic [2:0] rank;
  logic [2:0] tx_rank;
  logic [8:0] reg_bit;
  logic [6:0] rx_bit;
  logic [6:0] st_bit;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    tx_word = 32'h0000_0000;
    rank = 3'h0;
    tx_rank = 3'h0;
    reg_bit = 9'h000;
    rx_bit = 7'h00;
    st_bit = 7'h00;
    for (int j = 0; j < 4; j++)
    begin
      if (lanes[j])
      begin
        reg_bit = {chan, loc[3:2], j[1:0], 3'b000};
        rx_bit = {chan, rank[1:0], 3'b000};
        st_bit = (j[0] && lanes[j-1]) ?
          {chan, rank[1:0] - 2'b01, 3'b000} : rx_bit;
        tx_word[{tx_rank[1:0], 3'b000} +: 8] = i_wdata[j*8 +: 8];
        tx_rank = tx_rank + 3'h1;
        case (region)
          REGION_UART:
          begin
            rd_word[j*8 +: 8] = i_uart_regs[reg_bit +: 8];
          end
          REGION_CFG:
          begin
            rd_word[j*8 +: 8] = cfg_image[{loc[4:2], j[1:0]}];
          end
          REGION_DATA:
          begin
            rd_word[j*8 +: 8] = i_rx_bytes[rx_bit +: 8];
            rank = rank + 3'h1;
          end
          REGION_ERR:
          begin
            // odd lanes carry the status of the byte just below them, or of the next unread byte when that lane is off
            if (j[0])
            begin
              rd_word[j*8 +: 8] = i_line_status_value[st_bit +: 8];
            end
            else
            begin
              rd_word[j*8 +: 8] = i_rx_bytes[rx_bit +: 8];
              rank = rank + 3'h1;
            end
          end
          default:
          begin
            rd_word[j*8 +: 8] = 8'h00;
          end
        endcase
      end
    end
  end

  // ****************************************
  // read answer, one cycle after the strobe
  // ****************************************
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      o_rdata <= 32'h0000_0000;
    end
    else
    begin
      o_rdata <= i_rd ? rd_word : 32'h0000_0000;
    end
  end

  // ****************************************
  // receive pops
  // ****************************************
  logic rx_read;

  assign rx_read = i_rd && (region == REGION_DATA || region == REGION_ERR);

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      o_rx_pop <= 1'b0;
      o_rx_pop_chan <= 2'b00;
      o_rx_pop_count <= 3'h0;
    end
    else
    begin
      o_rx_pop <= rx_read && (rank != 3'h0);
      o_rx_pop_chan <= chan;
      o_rx_pop_count <= rx_read ? rank : 3'h0;
    end
  end

  // ****************************************
  // channel register port
  // ****************************************
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      o_uart_wr <= 1'b0;
      o_uart_rd <= 1'b0;
      o_uart_chan <= 2'b00;
      o_uart_offset <= 4'h0;
      o_uart_be <= 4'h0;
      o_uart_wdata <= 32'h0000_0000;
    end
    else
    begin
      o_uart_wr <= i_wr && (region == REGION_UART) && (lanes != 4'h0);
      o_uart_rd <= i_rd && (region == REGION_UART) && (lanes != 4'h0);
      o_uart_chan <= chan;
      o_uart_offset <= {loc[3:2], 2'b00};
      o_uart_be <= lanes;
      o_uart_wdata <= i_wdata;
    end
  end

  // ****************************************
  // transmit staging, writes refused while full
  // ****************************************
  logic tx_push;
  logic [TX_ENTRY_WIDTH-1:0] tx_head;

  // a write with no room is dropped: the host must watch o_tx_room
  assign tx_push = i_wr && (region == REGION_DATA) && (tx_rank != 3'h0);

  quad_uart_tx_buffer #(
    .WIDTH(TX_ENTRY_WIDTH),
    .DEPTH(TX_DEPTH)
  ) u_tx_buffer (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_in_valid(tx_push),
    .i_in_data({chan, tx_rank, tx_word}),
    .o_in_ready(o_tx_room),
    .o_out_valid(o_tx_valid),
    .o_out_data(tx_head),
    .i_out_ready(i_tx_ready)
  );

  assign o_tx_chan = tx_head[36:35];
  assign o_tx_count = tx_head[34:32];
  assign o_tx_bytes = tx_head[31:0];

  // ****************************************
  // shared configuration bytes
  // ****************************************
  logic [7:0] eight_x;
  logic [7:0] four_x;
  logic [7:0] soft_reset;
  logic [7:0] sleep_bits;

  quad_uart_shared_config u_shared_config (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_wr(i_wr && (region == REGION_CFG)),
    .i_chan(chan),
    .i_word(loc[4:2]),
    .i_lanes(lanes),
    .i_wdata(i_wdata),
    .i_int_flags(i_int_flags),
    .o_image(cfg_image),
    .o_eight_x(eight_x),
    .o_four_x(four_x),
    .o_soft_reset(soft_reset),
    .o_sleep(sleep_bits)
  );

  assign o_eight_times_sampling_select = eight_x[3:0];
  assign o_four_times_sampling_select = four_x[3:0];
  assign o_soft_reset = soft_reset[3:0];
  assign o_sleep = sleep_bits[3:0];

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  sequence rx_read_s;
    i_rd && region == REGION_DATA && lanes != 4'h0;
  endsequence

  sequence err_read_s;
    i_rd && region == REGION_ERR && (lanes & 4'h5) != 4'h0;
  endsequence

  reserved_reads_zero_a: assert property (
    (i_rd && hit && region == REGION_NONE) |=> o_rdata == 32'h0000_0000)
    else $error("reserved read returned data");

  data_pop_count_a: assert property (
    rx_read_s |=> o_rx_pop && o_rx_pop_count == $past($countones(lanes)))
    else $error("data window pop count wrong");

  err_pop_count_a: assert property (
    err_read_s |=> o_rx_pop &&
      o_rx_pop_count == $past($countones(lanes & 4'h5)))
    else $error("status window pop count wrong");

  miss_no_effect_a: assert property (
    ((i_rd || i_wr) && !hit) |=> !o_uart_wr && !o_uart_rd && !o_rx_pop)
    else $error("access outside the window had an effect");

  chan_block_a: assert property (
    (i_wr && region == REGION_UART && lanes != 4'h0) |=>
      o_uart_wr && o_uart_chan == $past(i_addr[11:10]))
    else $error("register write went to the wrong channel");

  reg_lanes_a: assert property (
    (i_rd && region == REGION_UART && lanes != 4'h0) |=>
      o_uart_rd && o_uart_be == $past(lanes) &&
      o_uart_offset == $past({i_addr[3:2], 2'b00}))
    else $error("register read lanes or offset wrong");

  tx_push_a: assert property (
    (tx_push && o_tx_room && !o_tx_valid) |=> o_tx_valid &&
      o_tx_count == $past(3'($countones(lanes))) ##0
      o_tx_chan == $past(chan))
    else $error("transmit write was not staged");

  err_no_write_a: assert property (
    (i_wr && region == REGION_ERR) |=> !o_uart_wr && !o_rx_pop)
    else $error("write to status window had an effect");

endmodule : quad_uart_memory_map_decoder

// *** channel_side_model.sv ***
// far side model: receive streams, register image and transmit sink
`timescale 1ns/10ps
module channel_side_model (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_pop,
  input wire logic [1:0] i_pop_chan,
  input wire logic [2:0] i_pop_count,
  input wire logic i_stall,
  output logic [511:0] o_uart_regs,
  output logic [127:0] o_rx_bytes,
  output logic [127:0] o_status,
  output logic o_tx_ready
);
  logic [3:0][7:0] head_q;

  // status is the inverted byte, so a lane pairing slip is visible
  always_comb
  begin
    for (int i = 0; i < 64; i++)
    begin
      o_uart_regs[8*i+:8] = 8'(i);
    end
    for (int c = 0; c < 4; c++)
    begin
      for (int k = 0; k < 4; k++)
      begin
        o_rx_bytes[8*(4*c+k)+:8] = head_q[c] + 8'(k);
        o_status[8*(4*c+k)+:8] = ~(head_q[c] + 8'(k));
      end
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      for (int c = 0; c < 4; c++)
      begin
        head_q[c] <= 8'(c * 64);
      end
    end
    else if (i_pop)
    begin
      head_q[i_pop_chan] <= head_q[i_pop_chan] + 8'(i_pop_count);
    end
  end

  assign o_tx_ready = !i_stall;
endmodule : channel_side_model

// *** testbench.sv ***
// self-checking bench for the memory window decoder
`timescale 1ns/10ps
module testbench;
  import quad_uart_map_pkg::*;
  localparam logic [19:0] BASE = 20'hABCDE;
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_base_load = 1'b0;
  logic [31:12] i_base_value = BASE;
  logic [31:0] i_addr = 32'h0;
  logic [3:0] i_byte_en = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic stall = 1'b1;
  logic [31:0] i_int_flags = 32'h87654321;
  logic [31:0] o_rdata, o_uart_wdata, o_tx_bytes;
  logic [511:0] i_uart_regs;
  logic [127:0] i_rx_bytes, i_line_status_value;
  logic o_uart_wr, o_uart_rd, o_rx_pop, o_tx_room, o_tx_valid, i_tx_ready;
  logic [1:0] o_uart_chan, o_rx_pop_chan, o_tx_chan;
  logic [3:0] o_uart_offset, o_uart_be, o_soft_reset, o_sleep;
  logic [3:0] o_eight_times_sampling_select, o_four_times_sampling_select;
  logic [2:0] o_rx_pop_count, o_tx_count;
  int n_fail = 0;
  int compares = 0;

  quad_uart_memory_map_decoder i_dut (
    .i_clock, .i_rst_b, .i_base_load, .i_base_value, .i_addr,
    .i_byte_en, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_uart_regs,
    .o_uart_wr, .o_uart_rd, .o_uart_chan, .o_uart_offset, .o_uart_be,
    .o_uart_wdata, .i_rx_bytes, .i_line_status_value, .o_rx_pop,
    .o_rx_pop_chan, .o_rx_pop_count, .o_tx_room, .o_tx_valid,
    .o_tx_chan, .o_tx_count, .o_tx_bytes, .i_tx_ready, .i_int_flags,
    .o_eight_times_sampling_select, .o_four_times_sampling_select,
    .o_soft_reset, .o_sleep
  );

  channel_side_model i_far (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_pop(o_rx_pop),
    .i_pop_chan(o_rx_pop_chan), .i_pop_count(o_rx_pop_count),
    .i_stall(stall), .o_uart_regs(i_uart_regs), .o_rx_bytes(i_rx_bytes),
    .o_status(i_line_status_value), .o_tx_ready(i_tx_ready)
  );

  always #5 i_clock = ~i_clock;

  // ****************************************
  // checks and bus cycles
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : chk

  function automatic logic [31:0] at(input logic [11:0] off);
    return {BASE, off};
  endfunction : at

  // returns one ns after the answer edge, so outputs have settled
  task automatic acc(input logic wr, input logic [31:0] adr,
    input logic [3:0] be, input logic [31:0] wd);
    @(posedge i_clock);
    i_addr <= adr;
    i_byte_en <= be;
    i_wdata <= wd;
    i_wr <= wr;
    i_rd <= !wr;
    @(posedge i_clock);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    #1;
  endtask : acc

  task automatic stop_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_window();
    chk("room at reset", 32'h1, 32'(o_tx_room));
    acc(1'b0, at(12'h500), 4'hF, 32'h0);
    chk("rdata unloaded", 32'h0, o_rdata);
    chk("pop unloaded", 32'h0, 32'(o_rx_pop));
    @(posedge i_clock);
    i_base_load <= 1'b1;
    @(posedge i_clock);
    i_base_load <= 1'b0;
    acc(1'b0, {BASE + 20'h1, 12'h500}, 4'hF, 32'h0);
    chk("rdata miss", 32'h0, o_rdata);
    chk("pop miss", 32'h0, 32'(o_rx_pop));
    $display("test window done");
  endtask : t_window

  task automatic t_config();
    acc(1'b1, at(12'h888), 4'h1, 32'h000000FF);
    chk("eight x", 32'h4, 32'(o_eight_times_sampling_select));
    acc(1'b1, at(12'hC88), 4'hF, 32'hFFFFFFFF);
    chk("eight x", 32'hC, 32'(o_eight_times_sampling_select));
    chk("four x", 32'h8, 32'(o_four_times_sampling_select));
    chk("sleep", 32'h8, 32'(o_sleep));
    chk("soft reset", 32'h8, 32'(o_soft_reset));
    acc(1'b0, at(12'h088), 4'hF, 32'h0);
    chk("soft reset end", 32'h0, 32'(o_soft_reset));
    chk("alias read", 32'h0800080C, o_rdata);
    acc(1'b1, at(12'h48C), 4'h3, 32'h0000FFFF);
    acc(1'b0, at(12'h88C), 4'h3, 32'h0);
    chk("read only", 32'h00005A01, o_rdata);
    acc(1'b0, at(12'h080), 4'hF, 32'h0);
    chk("int flags", 32'h87654321, o_rdata);
    acc(1'b0, at(12'hC90), 4'h8, 32'h0);
    chk("pin select", 32'hFF000000, o_rdata);
    acc(1'b1, at(12'h490), 4'h1, 32'h0000005A);
    acc(1'b0, at(12'hC90), 4'h1, 32'h0);
    chk("alias store", 32'h0000005A, o_rdata);
    $display("test config done");
  endtask : t_config

  task automatic t_regs();
    acc(1'b1, at(12'h406), 4'hF, 32'h12345678);
    chk("reg wr", 32'h1, 32'(o_uart_wr));
    chk("reg chan", 32'h1, 32'(o_uart_chan));
    chk("reg offset", 32'h4, 32'(o_uart_offset));
    chk("reg lanes", 32'hC, 32'(o_uart_be));
    chk("reg data", 32'h12340000, o_uart_wdata & 32'hFFFF0000);
    acc(1'b0, at(12'h808), 4'hF, 32'h0);
    chk("reg rd", 32'h1, 32'(o_uart_rd));
    chk("reg rdata", 32'h2B2A2928, o_rdata);
    acc(1'b0, at(12'hC0D), 4'hF, 32'h0);
    chk("reg 24 bit", 32'h3F3E3D00, o_rdata & 32'hFFFFFF00);
    $display("test regs done");
  endtask : t_regs

  task automatic t_reserved();
    logic [11:0] res [4] = '{12'h010, 12'h07C, 12'h49C, 12'hCFC};
    foreach (res[i])
    begin
      acc(1'b0, at(res[i]), 4'hF, 32'h0);
      chk("reserved read", 32'h0, o_rdata);
      chk("reserved side", 32'h0, 32'({o_uart_rd, o_rx_pop}));
    end
    acc(1'b1, at(12'h040), 4'hF, 32'hFFFFFFFF);
    chk("reserved write", 32'h0, 32'({o_uart_wr, o_tx_valid}));
    acc(1'b0, at(12'h098), 4'h8, 32'h0);
    chk("reserved byte", 32'h0, o_rdata);
    $display("test reserved done");
  endtask : t_reserved

  task automatic t_rx();
    logic [7:0] hd = 8'h40;
    logic [31:0] exp;
    logic [31:0] msk;
    for (int w = 1; w <= 4; w++)
    begin
      acc(1'b0, at(12'h500 + 12'(4 - w)), 4'hF, 32'h0);
      exp = 32'h0;
      msk = 32'h0;
      for (int i = 0; i < w; i++)
      begin
        exp[8*(4-w+i)+:8] = hd + 8'(i);
        msk[8*(4-w+i)+:8] = 8'hFF;
      end
      chk("rx data", exp, o_rdata & msk);
      chk("pop flag", 32'h1, 32'(o_rx_pop));
      chk("pop count", 32'(w), 32'(o_rx_pop_count));
      chk("pop chan", 32'h1, 32'(o_rx_pop_chan));
      hd = hd + 8'(w);
    end
    acc(1'b0, at(12'h200), 4'hF, 32'h0);
    chk("status read", 32'hFE01FF00, o_rdata);
    chk("status pops", 32'h2, 32'(o_rx_pop_count));
    acc(1'b0, at(12'h202), 4'hC, 32'h0);
    chk("status half", 32'hFD020000, o_rdata & 32'hFFFF0000);
    acc(1'b1, at(12'h200), 4'hF, 32'hFFFFFFFF);
    chk("status write", 32'h0, 32'(o_tx_valid));
    $display("test rx done");
  endtask : t_rx

  task automatic t_tx();
    acc(1'b1, at(12'hD00), 4'hF, 32'h44332211);
    chk("tx valid", 32'h1, 32'(o_tx_valid));
    chk("tx chan", 32'h3, 32'(o_tx_chan));
    chk("tx count", 32'h4, 32'(o_tx_count));
    chk("tx bytes", 32'h44332211, o_tx_bytes);
    acc(1'b1, at(12'hD02), 4'hC, 32'hAABB0000);
    chk("tx full", 32'h0, 32'(o_tx_room));
    // buffer full: this word must be dropped, not queued
    acc(1'b1, at(12'hD01), 4'h2, 32'h0000CC00);
    @(posedge i_clock);
    stall <= 1'b0;
    @(posedge i_clock);
    stall <= 1'b1;
    #1;
    chk("tx count 2", 32'h2, 32'(o_tx_count));
    chk("tx bytes 2", 32'h0000AABB, o_tx_bytes & 32'h0000FFFF);
    chk("tx room", 32'h1, 32'(o_tx_room));
    @(posedge i_clock);
    stall <= 1'b0;
    @(posedge i_clock);
    stall <= 1'b1;
    #1;
    chk("tx empty", 32'h0, 32'(o_tx_valid));
    $display("test tx done");
  endtask : t_tx

  initial
  begin
    #200000;
    n_fail++;
    stop_test();
  end

  initial
  begin
    repeat (5) @(posedge i_clock);
    i_rst_b <= 1'b1;
    t_window();
    t_config();
    t_regs();
    t_reserved();
    t_rx();
    t_tx();
    stop_test();
  end
endmodule : testbench
